// ### verilog/stc_pkg.sv
// constants and register map of the 16-bit timer/counter
// assumes an APB master on the register side and Fosc on i_clk
// Summary of operation
// - counts only while run_enable is set
// - wide_access_enable selects buffered 16-bit access
// - osc_clock_status shows oscillator drives system clock
// - divide select 11/10/01 gives 1:8/1:4/1:2
// - sec_osc_enable powers the crystal oscillator
// - ext_sync_bypass chooses unsynchronised external counting
// - count_source_select: instruction clock or external pin
// - external mode counts rising edges, oscillator if enabled
// - while running, oscillator pins forced input, read zero
// - wide low byte read copies live high into buffer
// - wide high write loads buffer, low write transfers
// - live high byte never accessed directly in wide mode
// - low write clears prescaler, high write does not
// - enabled oscillator keeps running in power modes
// - rollover FFFF to 0000 sets overflow flag
// - compare trigger zeroes count except in asynchronous external counting, software write wins
package stc_pkg;
   localparam logic [7:0] STC_OFS_CTRL = 8'h00;
   localparam logic [7:0] STC_OFS_LOW = 8'h04;
   localparam logic [7:0] STC_OFS_HIGH = 8'h08;
   localparam logic [7:0] STC_OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] STC_OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] STC_OFS_IRQ_CLR = 8'h14;
   localparam int STC_BIT_RUN = 0;
   localparam int STC_BIT_SRC = 1;
   localparam int STC_BIT_BYP = 2;
   localparam int STC_BIT_OSC = 3;
   localparam int STC_BIT_DIV_LO = 4;
   localparam int STC_BIT_DIV_HI = 5;
   localparam int STC_BIT_STATUS = 6;
   localparam int STC_BIT_WIDE = 7;
   localparam logic [7:0] STC_CTRL_RST = 8'h00;
   localparam logic [7:0] STC_CTRL_WMASK = 8'hBF;
   localparam logic [15:0] STC_CNT_RST = 16'h0000;
   localparam logic [15:0] STC_CNT_MAX = 16'hFFFF;
   localparam int STC_INSTR_DIV = 4;
endpackage

// ### verilog/stc_timer.sv
// 16-bit timer/counter with APB registers, prescaler and overflow irq
// assumes pins and oscillator output are asynchronous to i_clk (Fosc)
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module stc_sync (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_async,
   output logic o_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end
endmodule

module stc_timer import stc_pkg::*; #(
   parameter int INSTR_DIV = STC_INSTR_DIV
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   input wire logic i_ext_clk,
   input wire logic i_osc_clk,
   input wire logic i_osc_sys_clk,
   input wire logic i_cmp_trigger,
   input wire logic [1:0] i_port_dir,
   input wire logic [1:0] i_port_pin,
   output logic [1:0] o_pin_dir,
   output logic [1:0] o_port_read,
   output logic o_osc_enable,
   output logic o_irq
);
   initial begin
      if (INSTR_DIV < 1 || INSTR_DIV > 256) begin
         $error("INSTR_DIV out of range");
      end
   end

   logic [7:0] ctrl_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [7:0] buf_q;
   logic [2:0] pre_q;
   logic [2:0] pre_d;
   logic [7:0] itc_q;
   logic pend_q;
   logic edge_lvl_q;
   logic irq_stat_q;
   logic irq_en_q;
   logic [31:0] prdata_q;
   logic ext_lvl;
   logic osc_lvl;
   logic sys_lvl;

   stc_sync u_sync_ext (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async(i_ext_clk),
      .o_level(ext_lvl)
   );
   stc_sync u_sync_osc (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async(i_osc_clk),
      .o_level(osc_lvl)
   );
   stc_sync u_sync_sys (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async(i_osc_sys_clk),
      .o_level(sys_lvl)
   );

   // control fields
   wire run = ctrl_q[STC_BIT_RUN];
   wire src_ext = ctrl_q[STC_BIT_SRC];
   wire bypass = ctrl_q[STC_BIT_BYP];
   wire osc_en = ctrl_q[STC_BIT_OSC];
   wire wide = ctrl_q[STC_BIT_WIDE];
   wire [1:0] div_sel = ctrl_q[STC_BIT_DIV_HI:STC_BIT_DIV_LO];

   // apb decode
   wire setup = i_psel && !i_penable;
   wire access = i_psel && i_penable;
   wire hit_ctrl = i_paddr == STC_OFS_CTRL;
   wire hit_low = i_paddr == STC_OFS_LOW;
   wire hit_high = i_paddr == STC_OFS_HIGH;
   wire hit_stat = i_paddr == STC_OFS_IRQ_STAT;
   wire hit_en = i_paddr == STC_OFS_IRQ_EN;
   wire hit_clr = i_paddr == STC_OFS_IRQ_CLR;
   wire mapped = hit_ctrl || hit_low || hit_high || hit_stat || hit_en || hit_clr;
   wire wr = access && i_pwrite && mapped;
   wire wr_ctrl = wr && hit_ctrl;
   wire wr_low = wr && hit_low;
   wire wr_high = wr && hit_high;
   wire rd_low = setup && !i_pwrite && hit_low;
   wire [7:0] wdat = i_pwdata[7:0];

   // instruction cycle tick at Fosc/4
   wire itick = itc_q == 8'(INSTR_DIV - 1);

   // external source: oscillator output when enabled, else pin
   wire src_lvl = osc_en ? osc_lvl : ext_lvl;
   wire src_rise = src_lvl && !edge_lvl_q;
   // synchronised mode waits for the instruction tick, bypass counts at once
   wire ext_tick = bypass ? src_rise : ((src_rise || pend_q) && itick);
   wire src_tick = src_ext ? ext_tick : itick;

   // prescaler ratio 1,2,4,8
   wire [2:0] div_mask = div_sel == 2'b11 ? 3'h7 :
                         div_sel == 2'b10 ? 3'h3 :
                         div_sel == 2'b01 ? 3'h1 : 3'h0;
   wire pre_done = (pre_q & div_mask) == div_mask;
   wire cnt_inc = run && src_tick && pre_done;
   wire ovf = cnt_inc && cnt_q == STC_CNT_MAX;
   // trigger unreliable in asynchronous counting, so ignored there
   wire trig = i_cmp_trigger && !(src_ext && bypass);
   wire wr_cnt = wr_low || wr_high;

   // next count: trigger, then increment, software writes override both
   always_comb begin
      cnt_d = cnt_q;
      if (trig) begin
         cnt_d = STC_CNT_RST;
      end else if (cnt_inc) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (wr_low) begin
         cnt_d[7:0] = wdat;
         if (wide) begin
            cnt_d[15:8] = buf_q;
         end
      end
      if (wr_high && !wide) begin
         cnt_d[15:8] = wdat;
      end
   end

   // prescaler steps on source ticks, low write restarts it
   always_comb begin
      pre_d = pre_q;
      if (run && src_tick) begin
         pre_d = pre_done ? 3'h0 : pre_q + 3'h1;
      end
      if (wr_low) begin
         pre_d = 3'h0;
      end
   end

   // instruction divider, edge history and deferred synchronised edge
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         itc_q <= 8'h00;
         edge_lvl_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         itc_q <= itick ? 8'h00 : itc_q + 8'h01;
         edge_lvl_q <= src_lvl;
         pend_q <= (src_rise || pend_q) && !itick;
      end
   end

   // live count and prescaler state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= STC_CNT_RST;
         pre_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
         pre_q <= pre_d;
      end
   end

   // control register, status bit tracked every cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q <= STC_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= (wdat & STC_CTRL_WMASK) | (ctrl_q & ~STC_CTRL_WMASK);
         end
         ctrl_q[STC_BIT_STATUS] <= sys_lvl;
      end
   end

   // high byte buffer
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         buf_q <= 8'h00;
      end else if (wide && wr_high) begin
         buf_q <= wdat;
      end else if (wide && rd_low) begin
         buf_q <= cnt_q[15:8];
      end
   end

   // overflow sticky flag, set wins over clear
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_stat_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else begin
         irq_stat_q <= ovf || (irq_stat_q && !(wr && hit_clr && i_pwdata[0]));
         if (wr && hit_en) begin
            irq_en_q <= i_pwdata[0];
         end
      end
   end

   // read data captured in setup phase
   wire [7:0] high_view = wide ? buf_q : cnt_q[15:8];
   wire [7:0] rd_byte = hit_ctrl ? ctrl_q :
                        hit_low ? cnt_q[7:0] :
                        hit_high ? high_view :
                        hit_stat ? {7'h00, irq_stat_q} :
                        hit_en ? {7'h00, irq_en_q} : 8'h00;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= i_pwrite ? 32'h00000000 : {24'h000000, rd_byte};
      end
   end

   // zero wait states on every transfer
   assign o_pready = 1'b1;
   assign o_pslverr = access && !mapped;
   assign o_prdata = prdata_q;
   assign o_irq = irq_stat_q && irq_en_q;
   // oscillator power follows only its enable bit, in every power mode
   assign o_osc_enable = osc_en;
   assign o_pin_dir = run ? 2'b11 : i_port_dir;
   assign o_port_read = run ? 2'b00 : i_port_pin;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   run_hold_a: assert property (!run && !wr_cnt && !trig |=> cnt_q == $past(cnt_q))
      else $error("count moved while stopped");
   div_ratio_a: assert property (cnt_inc |-> (pre_q & div_mask) == div_mask)
      else $error("count advanced before prescaler done");
   low_clr_a: assert property (wr_low |=> pre_q == 3'h0)
      else $error("low write left prescaler");
   buf_copy_a: assert property (wide && rd_low && !wr_high |=> buf_q == $past(cnt_q[15:8]))
      else $error("buffer not loaded on low read");
   wide_load_a: assert property (wide && wr_low |=> cnt_q == {$past(buf_q), $past(wdat)})
      else $error("wide low write wrong");
   direct_high_a: assert property (!wide && wr_high |=> cnt_q[15:8] == $past(wdat))
      else $error("narrow high write wrong");
   ovf_flag_a: assert property (ovf |=> irq_stat_q ##0 o_irq == irq_en_q)
      else $error("overflow not latched");
   trig_zero_a: assert property (trig && !wr_cnt |=> cnt_q == STC_CNT_RST)
      else $error("trigger did not clear count");
   pin_force_a: assert property (run |-> o_pin_dir == 2'b11 && o_port_read == 2'b00)
      else $error("pins not forced while running");
   ext_sync_a: assert property (src_ext && !bypass && cnt_inc |-> itick)
      else $error("synchronised count off tick");

   ovf_c: cover property (ovf ##1 o_irq);
   wide_c: cover property (wide && wr_high ##[1:4] wide && wr_low);
   ext_c: cover property (src_ext && osc_en && cnt_inc);
   div8_c: cover property (div_sel == 2'b11 && cnt_inc);
   trig_c: cover property (trig ##1 cnt_q == STC_CNT_RST);

   // control register and status
   ctrl_write_a: assert property (wr_ctrl |=> (ctrl_q & STC_CTRL_WMASK) == ($past(wdat) & STC_CTRL_WMASK))
      else $error("control write not stored");
   ctrl_hold_a: assert property (!wr_ctrl |=> (ctrl_q & STC_CTRL_WMASK) == $past(ctrl_q & STC_CTRL_WMASK))
      else $error("control changed without write");
   status_bit_a: assert property (1'b1 |=> ctrl_q[STC_BIT_STATUS] == $past(sys_lvl))
      else $error("status bit not tracking");
   pin_release_a: assert property (!run |-> o_pin_dir == i_port_dir && o_port_read == i_port_pin)
      else $error("pins not released while stopped");

   // count sources and prescaler
   int_tick_a: assert property (!src_ext && cnt_inc |-> itick)
      else $error("timer count off instruction tick");
   byp_tick_a: assert property (src_ext && bypass && cnt_inc |-> src_rise)
      else $error("bypass count without edge");
   pend_clr_a: assert property (itick |=> !pend_q)
      else $error("pending edge kept past tick");
   sync_wait_a: assert property (src_rise && !itick |=> pend_q)
      else $error("edge lost before tick");
   div_one_a: assert property (div_sel == 2'b00 && run && src_tick |-> cnt_inc)
      else $error("undivided source tick lost");
   pre_step_a: assert property (run && src_tick && !pre_done && !wr_low |=> pre_q == $past(pre_q) + 3'h1)
      else $error("prescaler did not step");
   pre_idle_a: assert property (!run && !wr_low |=> pre_q == $past(pre_q))
      else $error("prescaler moved while stopped");
   high_keep_a: assert property (wr_high && !run |=> pre_q == $past(pre_q))
      else $error("high write touched prescaler");
   step_one_a: assert property (cnt_inc && !trig && !wr_cnt |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("count did not step by one");

   // wide access buffer
   wide_keep_a: assert property (wide && wr_high && !trig && !cnt_inc |=> cnt_q == $past(cnt_q))
      else $error("wide high write reached live count");
   wide_read_a: assert property (wide && setup && !i_pwrite && hit_high |=> o_prdata[7:0] == $past(buf_q))
      else $error("wide high read not from buffer");
   narrow_read_a: assert property (!wide && setup && !i_pwrite && hit_high |=> o_prdata[7:0] == $past(cnt_q[15:8]))
      else $error("narrow high read not live");
   buf_narrow_a: assert property (!wide |=> buf_q == $past(buf_q))
      else $error("buffer moved in narrow mode");

   // overflow, trigger and bus
   ovf_only_a: assert property ($rose(irq_stat_q) |-> $past(ovf))
      else $error("flag set without overflow");
   ovf_wrap_a: assert property (ovf && !trig && !wr_cnt |=> cnt_q == STC_CNT_RST)
      else $error("overflow did not wrap to zero");
   irq_clear_a: assert property (wr && hit_clr && i_pwdata[0] && !ovf |=> !irq_stat_q)
      else $error("flag not cleared");
   irq_sticky_a: assert property (irq_stat_q && !(wr && hit_clr) |=> irq_stat_q)
      else $error("flag dropped without clear");
   irq_enable_a: assert property (wr && hit_en |=> irq_en_q == $past(i_pwdata[0]))
      else $error("irq enable not stored");
   write_wins_a: assert property (trig && wr_low |=> cnt_q[7:0] == $past(wdat))
      else $error("trigger beat software write");
   unmapped_rd_a: assert property (setup && !mapped |=> o_prdata == 32'h00000000)
      else $error("unmapped read not zero");
   wr_rdata_a: assert property (setup && i_pwrite |=> o_prdata == 32'h00000000)
      else $error("write cycle returned data");
endmodule

// ### tb/stc_src_model.sv
// far-side clock sources: external count pin and secondary crystal
// assumes the bench calls pulse() for pin edges; crystal follows o_osc_enable
`timescale 1ns/1ps

module stc_src_model #(
   parameter int START_NS = 2000,
   parameter int HALF_NS = 250
) (
   input wire logic i_osc_enable,
   output logic o_ext_clk,
   output logic o_osc_clk
);
   initial begin
      o_ext_clk = 1'b0;
      o_osc_clk = 1'b0;
   end
   // crystal idles low until enabled and settled
   always begin
      wait (i_osc_enable === 1'b1);
      #(START_NS);
      while (i_osc_enable === 1'b1) begin
         #(HALF_NS);
         o_osc_clk = ~o_osc_clk;
      end
      o_osc_clk = 1'b0;
   end
   // pin stands low between bursts
   task automatic pulse(input int n);
      repeat (n) begin
         #(HALF_NS);
         o_ext_clk = 1'b1;
         #(HALF_NS);
         o_ext_clk = 1'b0;
      end
   endtask
endmodule

// ### tb/test_sixteen_bit_timer_counter.sv
// self-checking bench of the timer/counter over APB
// assumes stc_timer from verilog/ and the clock source model
`timescale 1ns/1ps

module test_sixteen_bit_timer_counter import stc_pkg::*;;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, serr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic ext_clk, osc_clk, osc_sys, cmp, osc_en, irq;
   logic [1:0] port_dir, port_pin, pin_dir, port_read;
   int err_count = 0;
   int samples_checked = 0;

   stc_timer dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_prdata(prdata), .i_ext_clk(ext_clk), .i_osc_clk(osc_clk),
      .i_osc_sys_clk(osc_sys), .i_cmp_trigger(cmp), .i_port_dir(port_dir),
      .i_port_pin(port_pin), .o_pin_dir(pin_dir), .o_port_read(port_read),
      .o_osc_enable(osc_en), .o_irq(irq));
   stc_src_model src_u (.i_osc_enable(osc_en), .o_ext_clk(ext_clk), .o_osc_clk(osc_clk));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
      samples_checked++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h out of range", $time, got);
      end
   endtask

   // one transfer, then one idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic t_ctrl();
      apb(0, STC_OFS_CTRL, 0);
      chk(rd, {24'h0, STC_CTRL_RST});
      apb(1, STC_OFS_CTRL, 32'h0000_00F8);
      apb(0, STC_OFS_CTRL, 0);
      chk(rd, 32'h0000_00B8);
      chk({31'h0, osc_en}, 32'h1);
      osc_sys <= 1'b1;
      repeat (10) @(posedge clk);
      apb(0, STC_OFS_CTRL, 0);
      chk(rd, 32'h0000_00F8);
      osc_sys <= 1'b0;
      apb(1, STC_OFS_CTRL, 0);
      chk({31'h0, osc_en}, 32'h0);
   endtask

   task automatic t_div();
      for (int c = 0; c < 4; c++) begin
         apb(1, STC_OFS_LOW, 0);
         apb(1, STC_OFS_CTRL, 32'h1 | (c << 4));
         chk({30'h0, pin_dir}, 32'h3);
         chk({30'h0, port_read}, 32'h0);
         repeat ((64 << c) - 3) @(posedge clk);
         apb(1, STC_OFS_CTRL, 0);
         apb(0, STC_OFS_LOW, 0);
         chk_rng(rd, 15, 17);
         v = rd;
         repeat (40) @(posedge clk);
         apb(0, STC_OFS_LOW, 0);
         chk(rd, v);
         chk({28'h0, pin_dir, port_read}, {28'h0, port_dir, port_pin});
      end
   endtask

   task automatic t_ext();
      for (int m = 0; m < 2; m++) begin
         apb(1, STC_OFS_LOW, 0);
         apb(1, STC_OFS_CTRL, (m == 0) ? 32'h07 : 32'h03);
         src_u.pulse(5);
         repeat (20) @(posedge clk);
         apb(1, STC_OFS_CTRL, 0);
         apb(0, STC_OFS_LOW, 0);
         chk(rd, 32'h5);
      end
   endtask

   task automatic t_wide();
      apb(1, STC_OFS_CTRL, 32'h80);
      apb(1, STC_OFS_HIGH, 32'h12);
      apb(1, STC_OFS_LOW, 32'h34);
      apb(1, STC_OFS_HIGH, 32'h56);
      apb(1, STC_OFS_CTRL, 0);
      apb(0, STC_OFS_HIGH, 0);
      chk(rd, 32'h12);
      apb(0, STC_OFS_LOW, 0);
      chk(rd, 32'h34);
      apb(1, STC_OFS_CTRL, 32'h80);
      apb(0, STC_OFS_LOW, 0);
      apb(0, STC_OFS_HIGH, 0);
      chk(rd, 32'h12);
      apb(1, STC_OFS_CTRL, 0);
      apb(1, STC_OFS_HIGH, 32'hAB);
      apb(0, STC_OFS_HIGH, 0);
      chk(rd, 32'hAB);
   endtask

   task automatic t_irq();
      apb(1, STC_OFS_HIGH, 32'hFF);
      apb(1, STC_OFS_LOW, 32'hFE);
      apb(1, STC_OFS_IRQ_EN, 1);
      apb(1, STC_OFS_CTRL, 1);
      repeat (20) @(posedge clk);
      apb(1, STC_OFS_CTRL, 0);
      apb(0, STC_OFS_IRQ_STAT, 0);
      chk(rd, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(1, STC_OFS_IRQ_EN, 0);
      chk({31'h0, irq}, 32'h0);
      apb(1, STC_OFS_IRQ_CLR, 1);
      apb(0, STC_OFS_IRQ_STAT, 0);
      chk(rd, 32'h0);
      apb(0, 8'h40, 0);
      chk({rd[31:1], serr}, 32'h1);
   endtask

   task automatic t_osc();
      apb(1, STC_OFS_CTRL, 32'h08);
      repeat (150) @(posedge clk);
      apb(1, STC_OFS_LOW, 0);
      apb(1, STC_OFS_CTRL, 32'h0F);
      repeat (250) @(posedge clk);
      apb(1, STC_OFS_CTRL, 32'h08);
      apb(0, STC_OFS_LOW, 0);
      chk_rng(rd, 9, 11);
      apb(1, STC_OFS_CTRL, 0);
   endtask

   task automatic t_rst();
      apb(1, STC_OFS_CTRL, 32'h8F);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({31'h0, osc_en}, 32'h0);
      chk({30'h0, pin_dir}, {30'h0, port_dir});
      apb(0, STC_OFS_CTRL, 0);
      chk(rd, {24'h0, STC_CTRL_RST});
   endtask

   task automatic t_trig();
      apb(1, STC_OFS_HIGH, 32'h01);
      apb(1, STC_OFS_LOW, 0);
      apb(1, STC_OFS_CTRL, 1);
      cmp <= 1'b1;
      @(posedge clk);
      cmp <= 1'b0;
      repeat (2) @(posedge clk);
      apb(1, STC_OFS_CTRL, 0);
      apb(0, STC_OFS_HIGH, 0);
      chk(rd, 32'h0);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, osc_sys, cmp} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      port_dir = 2'b01;
      port_pin = 2'b10;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_ctrl();
      t_div();
      t_ext();
      t_wide();
      t_irq();
      t_trig();
      t_osc();
      t_rst();
      give_verdict();
   end

   initial begin
      #1000000;
      err_count++;
      give_verdict();
   end
endmodule
